// ---- inc/cmpu_pkg.sv ----
// constants shared by the memory protect unit and its bound store
// assumes an 18-bit word, bit 0 the most significant, as on the i/o bus
package cmpu_pkg;
    // word and field widths
    localparam int WORD_W  = 18;   // memory and bus word
    localparam int BOUND_W = 5;    // boundary count width
    localparam int BANK_W  = 2;    // bank number, address bits 3..4
    localparam int LOW_W   = 3;    // address bits 5..7
    localparam int TRAP_W  = 5;    // trap vector width
    // field positions, bit 0 most significant
    localparam int BOUND_MSB  = 3;  // load data taken from bus bit 03
    localparam int BOUND_LSB  = 7;  // through bus bit 07
    localparam int OPC_MSB    = 0;  // opcode field bits 00..04
    localparam int OPC_LSB    = 4;
    localparam int MODE_BIT   = 2;  // saved mode bit of a word
    localparam int HALT_BIT   = 12; // operate halt micro bit
    localparam int SWITCH_BIT = 15; // operate switch-or micro bit
    // device selection code for this unit (17 octal)
    localparam logic [5:0] DEV_CODE = 6'h0f;
    // opcode decode patterns and masks over bits 00..04
    localparam logic [4:0] OPC_IO     = 5'h1c;
    localparam logic [4:0] OPC_IO_M   = 5'h1f;
    localparam logic [4:0] OPC_OPR    = 5'h1e;
    localparam logic [4:0] OPC_OPR_M  = 5'h1f;
    localparam logic [4:0] OPC_XCT    = 5'h08;
    localparam logic [4:0] OPC_XCT_M  = 5'h1e;
    // trap vectors: 20 octal with interrupts off, 0 with them on
    localparam logic [4:0] TRAP_PI_OFF = 5'h10;
    localparam logic [4:0] TRAP_PI_ON  = 5'h00;
    // values after reset
    localparam logic [4:0] BOUND_RESET = 5'h00;
    localparam logic [2:0] LOW_RESET   = 3'h0;
    localparam logic [1:0] BANK_RESET  = 2'h0;
endpackage

// ---- hw/cmpu_bound_cmp.sv ----
// boundary register and address comparator
// assumes load and fetch strobes are one-cycle pulses on i_clock
`timescale 1ns/10ps
module cmpu_bound_cmp #(
    parameter int BW = 5  // boundary width
) (
    input  wire logic          i_clock,
    input  wire logic          i_reset,
    input  wire logic          i_load,      // load pulse
    input  wire logic [BW-1:0] i_load_data, // new count
    input  wire logic          i_fetch,     // address capture
    input  wire logic [1:0]    i_bank,      // address bits 3..4
    input  wire logic [2:0]    i_low,       // address bits 5..7
    output logic               o_below      // address under bound
);
    // boundary count in 2000-octal blocks from zero
    logic [BW-1:0] bound_reg;
    // captured address field, bank bits on top
    logic [1:0] addr_bank;
    logic [2:0] addr_low;
    // bit 7 of the field is the least weight
    wire  [4:0] addr_field = {addr_bank, addr_low};
    // strictly less: equal or above has no effect
    wire        next_below = (addr_field < bound_reg);
    // parallel load of the whole count
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            bound_reg <= cmpu_pkg::BOUND_RESET;
        end else if (i_load) begin
            bound_reg <= i_load_data;
        end
    end
    // address field captured on the fetch strobe
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            addr_bank <= cmpu_pkg::BANK_RESET;
            addr_low  <= cmpu_pkg::LOW_RESET;
        end else if (i_fetch) begin
            addr_bank <= i_bank;
            addr_low  <= i_low;
        end
    end
    // registered compare result
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_below <= 1'b0;
        end else begin
            o_below <= next_below;
        end
    end
endmodule

// ---- hw/cmpu_core.sv ----
// memory protect unit: guard mode, violation monitor, trap request
// assumes all strobes are one-cycle pulses synchronous to i_clock
// Operation
// - load bus bits 03-07 into bound_reg
// - load only on select low, pulse four
// - bound counts 2000-octal blocks from zero
// - low two bits set protect 6000 octal
// - below_bound when address field strictly less
// - equal or above bound has no effect
// - bits 5-7 at fetch, 3-4 from bank
// - run state copies arm state on done
// - no run transfer during an io instruction
// - arm on enter, start key, debreak bit
// - disarm on jumps, reset, or violation
// - guarded state inhibits io timing pulses
// - guarded state blocks accumulator transfers
// - guarded state disables halt and switch-or
// - violation on listed instructions and references
// - suppress only halt or switch part
// - illegal ops decoded from buffer bits 00-04
// - illegal latch set at fetch entry
// - missing bank when wait and flag set
// - trap vector 20 or 0 by interrupts
// - trap only on violation in guarded mode
// - indirect, supervisor, key-started branch allowed
// - saved word bit 2 carries guarded state
`timescale 1ns/10ps
module cmpu_core #(
    parameter int WW = 18  // word width
) (
    // clock and io reset
    input  wire logic          i_clock,
    input  wire logic          i_reset,

    // programmed io bus
    input  wire logic [5:0]    i_device_code,
    input  wire logic          i_subdevice_select,
    input  wire logic          i_io_pulse_two,
    input  wire logic          i_io_pulse_four,
    input  wire logic [0:WW-1] i_io_bus,

    // processor address and timing
    input  wire logic          i_fetch_cycle,
    input  wire logic [2:0]    i_addr_low_bits,
    input  wire logic [1:0]    i_bank_addr_hi,
    input  wire logic          i_bank_ext_present,
    input  wire logic          i_instr_done,
    input  wire logic          i_device_io_instr,
    input  wire logic          i_fetch_entry_pulse,
    input  wire logic          i_wide_addressing_on,
    input  wire logic [0:WW-1] i_memory_buffer,

    // reference check
    input  wire logic          i_mem_ref_pulse,
    input  wire logic          i_direct_ref,
    input  wire logic          i_supervisor_instr,
    input  wire logic          i_branch_instr,
    input  wire logic          i_started_by_key,

    // missing bank detection
    input  wire logic          i_bank_reply_wait,
    input  wire logic          i_missing_bank_flag,

    // arm and disarm sources, then interrupts enabled for the trap vector
    input  wire logic          i_start_key,
    input  wire logic          i_protect_switch,
    input  wire logic          i_debreak_restore_instr,
    input  wire logic          i_intr_jump_zero,
    input  wire logic          i_priority_break_jump,
    input  wire logic          i_supervisor_jump,
    input  wire logic          i_program_interrupt,

    // guarded mode controls to the processor
    output logic               o_guarded_indicator,
    output logic               o_io_pulse_inhibit,
    output logic               o_block_ac_input,
    output logic               o_block_ac_output,
    output logic               o_halt_inhibit,
    output logic               o_console_inhibit,
    output logic               o_saved_mode_bit,

    // monitor and trap
    output logic               o_below_bound,
    output logic               o_violation_detect,
    output logic               o_trap_request,
    output logic [4:0]         o_trap_addr
);

    // opcode match under a mask, used by each decoder
    function automatic logic op_is(
        input logic [4:0] field,
        input logic [4:0] code,
        input logic [4:0] mask
    );
        op_is = ((field & mask) == code);
    endfunction

    // ---- state ----
    logic guarded_arm_state;   // armed, takes effect at done
    logic guarded_run_state;   // guarded mode active
    logic illegal_op_latch;    // opcode decoders enabled
    logic xct_seen;            // previous fetch was execute
    logic below_bound;         // compare result from store
    logic mode_out;            // mirrored guarded outputs
    logic viol_out;            // violation pulse
    logic trap_out;            // trap pulse
    logic [4:0] trap_vec;      // trap vector

    // ---- boundary load decode ----
    // device code matches this unit
    wire dev_hit =
        (i_device_code == cmpu_pkg::DEV_CODE);

    // load on pulse four with select at its low level
    // both share one code; the select level tells them apart
    wire load_bound_instr =
        dev_hit & i_io_pulse_four & ~i_subdevice_select;

    // enter guarded on pulse two with select high
    wire enter_guarded_instr =
        dev_hit & i_io_pulse_two & i_subdevice_select;

    // count carried on bus bits 03..07
    wire [4:0] bound_data =
        i_io_bus[cmpu_pkg::BOUND_MSB:cmpu_pkg::BOUND_LSB];
    // bank bits only when bank extension is fitted
    wire [1:0] bank_bits =
        i_bank_ext_present ? i_bank_addr_hi : cmpu_pkg::BANK_RESET;

    // boundary register and comparator
    cmpu_bound_cmp #(
        .BW (cmpu_pkg::BOUND_W)
    ) u_bound (
        .i_clock     (i_clock),
        .i_reset     (i_reset),
        .i_load      (load_bound_instr),
        .i_load_data (bound_data),
        .i_fetch     (i_fetch_cycle),
        .i_bank      (bank_bits),
        .i_low       (i_addr_low_bits),
        .o_below     (below_bound)
    );

    // ---- opcode decode ----
    // opcode field, bits 00..04
    wire [4:0] opc = i_memory_buffer[cmpu_pkg::OPC_MSB:cmpu_pkg::OPC_LSB];

    // io instruction class
    wire dec_io =
        op_is(opc, cmpu_pkg::OPC_IO, cmpu_pkg::OPC_IO_M);

    // operate class
    wire dec_opr =
        op_is(opc, cmpu_pkg::OPC_OPR, cmpu_pkg::OPC_OPR_M);

    // execute, direct or indirect
    wire dec_xct =
        op_is(opc, cmpu_pkg::OPC_XCT, cmpu_pkg::OPC_XCT_M);

    // halt micro bit inside an operate word
    wire dec_halt =
        dec_opr & i_memory_buffer[cmpu_pkg::HALT_BIT];

    // switch-or micro bit inside an operate word
    wire dec_console =
        dec_opr & i_memory_buffer[cmpu_pkg::SWITCH_BIT];

    // ---- violation sources ----
    // second execute in a chain; the first passes
    wire v_xct =
        illegal_op_latch & dec_xct & xct_seen;

    // halt, switch-or and any io instruction
    wire v_illegal = illegal_op_latch &
        (dec_halt | dec_console | dec_io);

    // missing bank: reply still awaited and flag raised
    wire v_bank =
        i_bank_reply_wait & i_missing_bank_flag;

    // branch into region unless started by the key
    wire v_branch =
        i_branch_instr & ~i_started_by_key;

    // direct reference by anything but a supervisor trap
    // indirect references into the region pass
    wire v_direct =
        i_direct_ref & ~i_supervisor_instr;

    // protected region reference, checked on the strobe
    wire v_region = i_mem_ref_pulse & below_bound &
        (v_branch | v_direct);

    // any violation this cycle
    wire violation =
        v_xct | v_illegal | v_bank | v_region;

    // trap needs both mode bits set as in the arm/run pair
    // outside guarded mode a violation is only reported
    wire trap_fire = violation & guarded_run_state &
        guarded_arm_state;

    // ---- arm state next value ----
    // set sources
    wire arm_set = enter_guarded_instr |
        (i_start_key & i_protect_switch) |
        (i_debreak_restore_instr &
         i_memory_buffer[cmpu_pkg::MODE_BIT]);
    // clear sources
    wire arm_clr = i_intr_jump_zero | i_priority_break_jump |
        i_supervisor_jump | violation;
    // clearing wins so a violation always disarms
    // an arming request in the same cycle is dropped
    wire next_arm = arm_clr ? 1'b0 :
        (arm_set ? 1'b1 : guarded_arm_state);

    // ---- run state next value ----
    // transfer on done, held off while an io instruction runs
    // so the io op that arms guarded mode ends unguarded
    wire run_take =
        i_instr_done & ~i_device_io_instr;

    // copy the armed state, set or clear
    wire next_run =
        run_take ? guarded_arm_state : guarded_run_state;

    // ---- illegal latch next value ----
    // set at fetch entry with wide addressing off
    wire latch_set =
        i_fetch_entry_pulse & ~i_wide_addressing_on;

    // opens the decoders for the following cycle only
    wire next_latch = latch_set;

    // ---- execute chain next value ----
    // follows the decoded class each time decoders open
    wire next_xct_seen =
        illegal_op_latch ? dec_xct : xct_seen;

    // ---- trap vector ----
    // zero with interrupts enabled, 20 octal otherwise
    wire [4:0] next_vec = i_program_interrupt ?
        cmpu_pkg::TRAP_PI_ON : cmpu_pkg::TRAP_PI_OFF;

    // arm state register
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            guarded_arm_state <= 1'b0;
        end else begin
            guarded_arm_state <= next_arm;
        end
    end

    // run state register
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            guarded_run_state <= 1'b0;
        end else begin
            guarded_run_state <= next_run;
        end
    end

    // illegal opcode latch
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            illegal_op_latch <= 1'b0;
        end else begin
            illegal_op_latch <= next_latch;
        end
    end

    // execute chain tracker
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            xct_seen <= 1'b0;
        end else begin
            xct_seen <= next_xct_seen;
        end
    end

    // guarded controls follow the run state next value
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            mode_out <= 1'b0;
        end else begin
            mode_out <= next_run;
        end
    end

    // violation pulse, one per violating cycle
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            viol_out <= 1'b0;
        end else begin
            viol_out <= violation;
        end
    end

    // trap pulse, only for a violation in guarded mode
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            trap_out <= 1'b0;
        end else begin
            trap_out <= trap_fire;
        end
    end

    // vector held from the trap onward
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            trap_vec <= cmpu_pkg::TRAP_PI_OFF;
        end else if (trap_fire) begin
            trap_vec <= next_vec;
        end
    end

    // ---- outputs, each from a flip-flop ----
    // mode seen by the processor io control
    assign o_guarded_indicator = mode_out;

    // timing pulses suppressed, so every io op is dead
    assign o_io_pulse_inhibit  = mode_out;

    // no input into the accumulator
    assign o_block_ac_input    = mode_out;

    // no output from the accumulator
    assign o_block_ac_output   = mode_out;

    // only the halt micro function is stopped
    assign o_halt_inhibit      = mode_out;

    // only the switch-or micro function is stopped
    assign o_console_inhibit   = mode_out;

    // bit 2 of any saved state word
    assign o_saved_mode_bit    = mode_out;

    // compare result straight from the store
    assign o_below_bound       = below_bound;

    // one-cycle violation marker
    assign o_violation_detect  = viol_out;

    // one-cycle trap request to the processor
    assign o_trap_request      = trap_out;

    // jump target of the effective subroutine call
    assign o_trap_addr         = trap_vec;

endmodule

// ---- sim/cmpu_core_props.sv ----
// concurrent checks on the memory protect unit ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/10ps
module cmpu_core_props (
    input wire logic        i_clock,
    input wire logic        i_reset,
    input wire logic [5:0]  i_device_code,
    input wire logic        i_subdevice_select,
    input wire logic        i_io_pulse_four,
    input wire logic [0:17] i_io_bus,
    input wire logic        i_fetch_cycle,
    input wire logic [2:0]  i_addr_low_bits,
    input wire logic [1:0]  i_bank_addr_hi,
    input wire logic        i_bank_ext_present,
    input wire logic        i_instr_done,
    input wire logic        i_device_io_instr,
    input wire logic        i_fetch_entry_pulse,
    input wire logic        i_wide_addressing_on,
    input wire logic [0:17] i_memory_buffer,
    input wire logic        i_mem_ref_pulse,
    input wire logic        i_direct_ref,
    input wire logic        i_supervisor_instr,
    input wire logic        i_bank_reply_wait,
    input wire logic        i_missing_bank_flag,
    input wire logic        i_program_interrupt,
    input wire logic        o_guarded_indicator,
    input wire logic        o_below_bound,
    input wire logic        o_violation_detect,
    input wire logic        o_trap_request,
    input wire logic [4:0]  o_trap_addr
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    logic [4:0] bnd; // shadow boundary count
    logic [4:0] adr; // shadow address field
    wire        ld = i_io_pulse_four && i_device_code == 6'h0f && !i_subdevice_select;
    wire  [1:0] bk = i_bank_ext_present ? i_bank_addr_hi : 2'h0;
    // shadow of the load and the fetch capture
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            bnd <= 5'h00;
            adr <= 5'h00;
        end else begin
            bnd <= ld ? i_io_bus[3:7] : bnd;
            adr <= i_fetch_cycle ? {bk, i_addr_low_bits} : adr;
        end
    end
    sequence s_illegal_io;
        i_fetch_entry_pulse && !i_wide_addressing_on ##1 i_memory_buffer[0:4] == 5'h1c;
    endsequence
    sequence s_viol_done;
        o_violation_detect ##1 (i_instr_done && !i_device_io_instr);
    endsequence
    property p_below;
        o_below_bound == $past(adr < bnd);
    endproperty
    property p_io_done;
        i_instr_done && i_device_io_instr |=> $stable(o_guarded_indicator);
    endproperty
    property p_trap;
        o_trap_request |-> o_violation_detect && $past(o_guarded_indicator);
    endproperty
    property p_vec;
        o_trap_request |-> o_trap_addr == ($past(i_program_interrupt) ? 5'h00 : 5'h10);
    endproperty
    property p_bank;
        i_bank_reply_wait && i_missing_bank_flag |=> o_violation_detect;
    endproperty
    property p_io_op;
        s_illegal_io |=> o_violation_detect;
    endproperty
    property p_region;
        i_mem_ref_pulse && o_below_bound && i_direct_ref && !i_supervisor_instr
            |=> o_violation_detect;
    endproperty
    property p_disarm;
        s_viol_done |=> !o_guarded_indicator;
    endproperty
    a_below: assert property (p_below) else $error("below flag wrong");
    a_io_done: assert property (p_io_done) else $error("mode moved in io");
    a_trap: assert property (p_trap) else $error("trap outside guard");
    a_vec: assert property (p_vec) else $error("trap vector wrong");
    a_bank: assert property (p_bank) else $error("missing bank unseen");
    a_io_op: assert property (p_io_op) else $error("io opcode unseen");
    a_region: assert property (p_region) else $error("region ref unseen");
    a_disarm: assert property (p_disarm) else $error("mode kept");
endmodule
bind cmpu_core cmpu_core_props u_props (.i_clock(i_clock), .i_reset(i_reset),
    .i_device_code(i_device_code), .i_subdevice_select(i_subdevice_select),
    .i_io_pulse_four(i_io_pulse_four), .i_io_bus(i_io_bus), .i_fetch_cycle(i_fetch_cycle),
    .i_addr_low_bits(i_addr_low_bits), .i_bank_addr_hi(i_bank_addr_hi),
    .i_bank_ext_present(i_bank_ext_present), .i_instr_done(i_instr_done),
    .i_device_io_instr(i_device_io_instr), .i_fetch_entry_pulse(i_fetch_entry_pulse),
    .i_wide_addressing_on(i_wide_addressing_on), .i_memory_buffer(i_memory_buffer),
    .i_mem_ref_pulse(i_mem_ref_pulse), .i_direct_ref(i_direct_ref),
    .i_supervisor_instr(i_supervisor_instr), .i_bank_reply_wait(i_bank_reply_wait),
    .i_missing_bank_flag(i_missing_bank_flag), .i_program_interrupt(i_program_interrupt),
    .o_guarded_indicator(o_guarded_indicator), .o_below_bound(o_below_bound),
    .o_violation_detect(o_violation_detect), .o_trap_request(o_trap_request),
    .o_trap_addr(o_trap_addr));

// ---- sim/cmpu_cpu_model.sv ----
// processor side model: runs one io instruction per request
// assumes the bench spaces requests at least six cycles apart
`timescale 1ns/10ps
module cmpu_cpu_model (
    input  wire logic        i_clock,            // processor clock
    input  wire logic        i_go,               // start an io instruction
    input  wire logic        i_sub,              // subdevice select level
    input  wire logic [0:17] i_ac,               // word sent on the bus
    input  wire logic        i_inhibit,          // guarded mode from the unit
    output logic [5:0]       o_device_code = 6'h30,      // device select
    output logic             o_subdevice_select = 1'h1,  // subdevice line
    output logic             o_io_pulse_two = 1'h0,      // timing pulse 2
    output logic             o_io_pulse_four = 1'h0,     // timing pulse 4
    output logic [0:17]      o_io_bus = 18'h2aaaa,       // bus data
    output logic             o_device_io_instr = 1'h0,   // io instruction active
    output logic             o_instr_done = 1'h0         // end of instruction
);
    logic [2:0] step = 3'h0; // instruction phase, 0 idle
    // phases: select, pulse two, pulse four, done, release
    always @(posedge i_clock) begin
        o_io_pulse_two <= step == 3'h1 && !i_inhibit;
        o_io_pulse_four <= step == 3'h2 && !i_inhibit;
        o_instr_done <= step == 3'h3;
        if (i_go && step == 3'h0) begin
            step <= 3'h1;
            o_device_code <= 6'h0f;
            o_subdevice_select <= i_sub;
            o_io_bus <= i_ac;
            o_device_io_instr <= 1'h1;
        end else if (step == 3'h4) begin
            // released bus shows no stale word
            step <= 3'h0;
            o_device_code <= 6'h30;
            o_io_bus <= ~o_io_bus;
            o_device_io_instr <= 1'h0;
        end else if (step != 3'h0) begin
            step <= step + 3'h1;
        end
    end
endmodule

// ---- sim/cmpu_core_tb.sv ----
// self-checking bench for the memory protect unit
// assumes the processor model issues every io instruction
`timescale 1ns/10ps
module cmpu_core_tb;
    logic        i_clock;   // 20 MHz clock
    logic        i_reset;   // sync reset
    logic [8:0]  pl;        // fetch, entry, ref, key, dbr, jz, brk, sj, done
    logic [9:0]  lv;        // ext, wide, dir, sup, br, keyrun, wait, miss, pi, sw
    logic [0:17] mb;        // fetched word
    logic [0:17] ac;        // io instruction word
    logic [1:0]  bank;      // address bits 3..4
    logic [2:0]  low;       // address bits 5..7
    logic        go, sub;   // model request
    wire  [5:0]  code;      // model device code
    wire  [0:17] bus;       // model io bus
    wire         sel, p2, p4, ioi, mdone, g, ioinh, aci, aco, hinh, cinh, smb, below, viol, trap;
    wire  [4:0]  taddr;     // trap vector
    int          num_errors = 0;
    int          tests_run = 0;
    logic [4:0]  bt [3] = '{5'h03, 5'h1f, 5'h00};
    logic [4:0]  rv [5] = '{5'h00, 5'h03, 5'h11, 5'h14, 5'h0c};
    logic [18:0] ot [7] = '{19'h08000, 19'h10000, 19'h50000, 19'h78000, 19'h3c000,
                            19'h7c020, 19'h7c004};
    cmpu_cpu_model cpu (.i_clock(i_clock), .i_go(go), .i_sub(sub), .i_ac(ac),
        .i_inhibit(ioinh), .o_device_code(code), .o_subdevice_select(sel),
        .o_io_pulse_two(p2), .o_io_pulse_four(p4), .o_io_bus(bus),
        .o_device_io_instr(ioi), .o_instr_done(mdone));
    cmpu_core DUT (.i_clock(i_clock), .i_reset(i_reset), .i_device_code(code),
        .i_subdevice_select(sel), .i_io_pulse_two(p2), .i_io_pulse_four(p4), .i_io_bus(bus),
        .i_fetch_cycle(pl[0]), .i_addr_low_bits(low), .i_bank_addr_hi(bank),
        .i_bank_ext_present(lv[0]), .i_instr_done(pl[8] | mdone), .i_device_io_instr(ioi),
        .i_fetch_entry_pulse(pl[1]), .i_wide_addressing_on(lv[1]), .i_memory_buffer(mb),
        .i_mem_ref_pulse(pl[2]), .i_direct_ref(lv[2]), .i_supervisor_instr(lv[3]),
        .i_branch_instr(lv[4]), .i_started_by_key(lv[5]), .i_bank_reply_wait(lv[6]),
        .i_missing_bank_flag(lv[7]), .i_start_key(pl[3]), .i_protect_switch(lv[9]),
        .i_debreak_restore_instr(pl[4]), .i_intr_jump_zero(pl[5]),
        .i_priority_break_jump(pl[6]), .i_supervisor_jump(pl[7]),
        .i_program_interrupt(lv[8]), .o_guarded_indicator(g), .o_io_pulse_inhibit(ioinh),
        .o_block_ac_input(aci), .o_block_ac_output(aco), .o_halt_inhibit(hinh),
        .o_console_inhibit(cinh), .o_saved_mode_bit(smb), .o_below_bound(below),
        .o_violation_detect(viol), .o_trap_request(trap), .o_trap_addr(taddr));
    initial begin
        i_clock = 1'h0;
        forever #25 i_clock = ~i_clock;
    end
    task automatic tick(int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one-cycle strobe; returns just after its sampling edge
    task automatic pulse(int k);
        @(posedge i_clock);
        pl[k] <= 1'h1;
        @(posedge i_clock);
        pl[k] <= 1'h0;
        #1;
    endtask
    task automatic device_io_instr(logic s, logic [0:17] w);
        @(posedge i_clock);
        go <= 1'h1;
        sub <= s;
        ac <= w;
        @(posedge i_clock);
        go <= 1'h0;
        tick(6);
    endtask
    // capture an address field, wait for the compare
    task automatic fetch(logic [4:0] f, logic x);
        @(posedge i_clock);
        {bank, low} <= f;
        lv[0] <= x;
        pulse(0);
        tick(1);
    endtask
    task automatic entry(logic [0:17] w);
        @(posedge i_clock);
        mb <= w;
        pulse(1);
        tick(1);
    endtask
    task automatic give_verdict();
        if (num_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge i_clock);
        num_errors++;
        give_verdict();
    end
    initial begin
        i_reset = 1'h1;
        pl = 9'h000;
        lv = 10'h205;
        mb = 18'h00000;
        ac = 18'h00000;
        bank = 2'h0;
        low = 3'h0;
        go = 1'h0;
        sub = 1'h0;
        repeat (6) @(posedge i_clock);
        i_reset <= 1'h0;
        tick(1);
        chk("reset", {4'h0, g, below, viol, trap}, 8'h00);
        chk("reset vector", {3'h0, taddr}, 8'h10);
        foreach (bt[i]) begin
            device_io_instr(1'h0, {3'h0, bt[i], 10'h000});
            fetch(bt[i] - 5'h01, 1'h1);
            chk("below", below, {7'h00, bt[i] != 5'h00});
            fetch(bt[i], 1'h1);
            chk("equal", below, 8'h00);
        end
        device_io_instr(1'h0, {3'h0, 5'h03, 10'h000});
        fetch(5'h19, 1'h0);
        chk("no bank", below, 8'h01);
        fetch(5'h19, 1'h1);
        chk("bank", below, 8'h00);
        fetch(5'h01, 1'h1);
        foreach (rv[i]) begin
            @(posedge i_clock);
            lv[5:2] <= rv[i][3:0];
            pulse(2);
            chk("region", viol, {7'h00, rv[i][4]});
        end
        foreach (ot[i]) begin
            entry(ot[i][17:0]);
            chk("opcode", viol, {7'h00, ot[i][18]});
        end
        @(posedge i_clock);
        lv[1] <= 1'h1;
        entry(18'h38000);
        chk("wide", viol, 8'h00);
        @(posedge i_clock);
        {lv[7:6], lv[1]} <= 3'h6;
        @(posedge i_clock);
        lv[7:6] <= 2'h0;
        #1;
        chk("bank miss", {viol, trap}, 8'h02);
        for (int p = 0; p < 2; p++) begin
            @(posedge i_clock);
            lv[8] <= p[0];
            device_io_instr(1'h1, 18'h00000);
            chk("io done", g, 8'h00);
            pulse(8);
            chk("guards", {g, ioinh, aci, aco, hinh, cinh, smb}, 8'h7f);
            device_io_instr(1'h0, 18'h00000);
            fetch(5'h01, 1'h1);
            chk("kept bound", below, 8'h01);
            entry(18'h38000);
            chk("trap", {trap, taddr}, {3'h1, p[0] ? 5'h00 : 5'h10});
            pulse(8);
            chk("disarm", g, 8'h00);
        end
        for (int k = 0; k < 3; k++) begin
            @(posedge i_clock);
            mb <= 18'h08000;
            pulse(k == 1 ? 4 : 3);
            pulse(8);
            chk("arm", g, 8'h01);
            pulse(5 + k);
            pulse(8);
            chk("jump", g, 8'h00);
        end
        @(posedge i_clock);
        lv[9] <= 1'h0;
        pulse(3);
        pulse(8);
        chk("switch down", g, 8'h00);
        give_verdict();
    end
endmodule
